/* hdl/tsc_pkg.sv */
package tsc_pkg;
    localparam int CLK_HZ = 10_000_000;
    localparam int BIAS_MS = 24;
    localparam int PRI_MS = 35;
    localparam int STD_MS = 235;
    localparam int BIT_US = 500;
    // Comparator deglitch time, in microseconds.
    localparam int DEG_US = 10;
    localparam int BIAS_CYC = BIAS_MS * (CLK_HZ / 1000);
    localparam int PRI_CYC = PRI_MS * (CLK_HZ / 1000);
    localparam int STD_CYC = STD_MS * (CLK_HZ / 1000);
    localparam int HALF_BIT_CYC = (BIT_US * (CLK_HZ / 1_000_000)) / 2;
    localparam int DEG_CYC = DEG_US * (CLK_HZ / 1_000_000);
    localparam int FRAME_BITS = 11;
    localparam int PKT_BYTES = 3;
    localparam int TMR_W = 22;
    localparam int PWR_W = 16;
    localparam logic [7:0] EPT_HDR = 8'h02;
    localparam logic [7:0] RXPWR_HDR = 8'h04;
    localparam logic [7:0] EPT_UNKNOWN = 8'h00;
    localparam logic [7:0] EPT_INT_FAULT = 8'h02;
    localparam logic [7:0] EPT_OVER_TEMP = 8'h03;
    localparam logic [7:0] PWR_SAT = 8'hff;
    localparam int SYN_HOT = 0;
    localparam int SYN_COLD = 1;
    localparam int SYN_CTRL = 2;
    localparam int SYN_DIE_HOT = 3;
    localparam int SYN_DIE_COOL = 4;
    localparam int SYN_N = 5;
    typedef enum logic [1:0] {TSC_BIAS, TSC_MONITOR, TSC_HALT} tsc_phase_e;
endpackage

/* hdl/tsc_biphase_tx.sv */
`timescale 1ns/1ps
module tsc_biphase_tx #(
    parameter int HALF_CYC = tsc_pkg::HALF_BIT_CYC,
    parameter int BYTES = tsc_pkg::PKT_BYTES
) (
    input wire logic sys_clk,
    input wire logic nrst,
    input wire logic start,
    input wire logic [BYTES*8-1:0] pkt,
    output logic busy,
    output logic mod_out
);
    localparam int NB = BYTES * tsc_pkg::FRAME_BITS;
    localparam int CW = $clog2(HALF_CYC + 1);
    localparam int BW = $clog2(NB + 1);

    logic [NB-1:0] frame;
    logic [NB-1:0] shift_r;
    logic [BW-1:0] left_r;
    logic [CW-1:0] half_r;
    logic second_r;
    logic busy_r;
    logic mod_r;

    always_comb begin
        frame = '0;
        for (int i = 0; i < BYTES; i++) begin
            frame[i*tsc_pkg::FRAME_BITS +: tsc_pkg::FRAME_BITS] =
                {1'b1, ~^pkt[i*8 +: 8], pkt[i*8 +: 8], 1'b0};
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            shift_r <= '0;
            left_r <= '0;
            half_r <= '0;
            second_r <= 1'b0;
            busy_r <= 1'b0;
            mod_r <= 1'b0;
        end else if (!busy_r) begin
            if (start) begin
                shift_r <= frame;
                left_r <= BW'(NB);
                half_r <= '0;
                second_r <= 1'b0;
                busy_r <= 1'b1;
                mod_r <= ~mod_r;
            end
        end else if (half_r == CW'(HALF_CYC - 1)) begin
            half_r <= '0;
            if (!second_r) begin
                second_r <= 1'b1;
                if (shift_r[0]) begin
                    mod_r <= ~mod_r;
                end
            end else begin
                second_r <= 1'b0;
                shift_r <= shift_r >> 1;
                left_r <= left_r - BW'(1);
                if (left_r == BW'(1)) begin
                    busy_r <= 1'b0;
                end else begin
                    mod_r <= ~mod_r;
                end
            end
        end else begin
            half_r <= half_r + CW'(1);
        end
    end

    assign busy = busy_r;
    assign mod_out = mod_r;
endmodule

/* hdl/tsc_ctrl.sv */
`timescale 1ns/1ps
module tsc_ctrl #(
    parameter int BIAS_CYC = tsc_pkg::BIAS_CYC,
    parameter int PRI_CYC = tsc_pkg::PRI_CYC,
    parameter int STD_CYC = tsc_pkg::STD_CYC,
    parameter int HALF_BIT_CYC = tsc_pkg::HALF_BIT_CYC,
    parameter int DEG_CYC = tsc_pkg::DEG_CYC,
    parameter int PWR_W = tsc_pkg::PWR_W
) (
    input wire logic sys_clk,
    input wire logic nrst,
    input wire logic hot_cmp,
    input wire logic cold_cmp,
    input wire logic ctrl_high_cmp,
    input wire logic die_hot,
    input wire logic die_cool,
    input wire logic priority_period,
    input wire logic [PWR_W-1:0] out_power,
    input wire logic [PWR_W-1:0] loss_power,
    output logic temp_bias_read_window,
    output logic sense_pin_o,
    output logic sense_pin_oe,
    output logic ldo_en,
    output logic ctrl_flag,
    output logic transfer_ended,
    output logic [7:0] ept_reason,
    output logic [PWR_W:0] rx_power,
    output logic comm_mod,
    output logic comm_busy
);
    localparam int TW = tsc_pkg::TMR_W;
    localparam int DW = $clog2(DEG_CYC + 1);

    logic [tsc_pkg::SYN_N-1:0] raw;
    logic [tsc_pkg::SYN_N-1:0] sync1_r;
    logic [tsc_pkg::SYN_N-1:0] sync2_r;
    tsc_pkg::tsc_phase_e phase_r;
    logic [TW-1:0] tmr_r;
    logic [TW-1:0] mon_len;
    logic bias_end;
    logic mon_end;
    logic [1:0] trip;
    logic [DW-1:0] deg_r [2];
    logic temp_fault;
    logic ext_fault;
    logic ctrl_flag_r;
    logic ts_off_r;
    logic die_off_r;
    logic die_trip;
    logic ept_req_r;
    logic [7:0] reason_r;
    logic pwr_req_r;
    logic [PWR_W:0] rx_power_r;
    logic [7:0] pwr_byte;
    logic tx_busy;
    logic tx_start;
    logic [7:0] hdr;
    logic [7:0] body;
    logic [23:0] pkt;
    logic ended_r;

    // Pins and analog comparator outputs cross into this clock domain here.
    assign raw = {die_cool, die_hot, ctrl_high_cmp, cold_cmp, hot_cmp};

    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            sync1_r <= '0;
            sync2_r <= '0;
        end else begin
            sync1_r <= raw;
            sync2_r <= sync1_r;
        end
    end

    assign mon_len = priority_period ? TW'(PRI_CYC) : TW'(STD_CYC);
    assign bias_end = (phase_r == tsc_pkg::TSC_BIAS) && (tmr_r == TW'(BIAS_CYC - 1));
    assign mon_end = (phase_r == tsc_pkg::TSC_MONITOR) && (tmr_r == mon_len - TW'(1));

    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            phase_r <= tsc_pkg::TSC_BIAS;
            tmr_r <= '0;
        end else if (ts_off_r) begin
            phase_r <= tsc_pkg::TSC_HALT;
            tmr_r <= '0;
        end else if (bias_end) begin
            phase_r <= tsc_pkg::TSC_MONITOR;
            tmr_r <= '0;
        end else if (mon_end) begin
            phase_r <= tsc_pkg::TSC_BIAS;
            tmr_r <= '0;
        end else begin
            tmr_r <= tmr_r + TW'(1);
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            temp_bias_read_window <= 1'b0;
        end else begin
            temp_bias_read_window <= (phase_r == tsc_pkg::TSC_BIAS) && !bias_end && !ts_off_r;
        end
    end

    // The bias source only ever drives the pin high; when released the host may move it.
    assign sense_pin_o = temp_bias_read_window;
    assign sense_pin_oe = temp_bias_read_window;

    for (genvar i = 0; i < 2; i++) begin : g_deg
        always_ff @(posedge sys_clk) begin
            if (!nrst) begin
                deg_r[i] <= '0;
            end else if (!temp_bias_read_window || !sync2_r[i]) begin
                deg_r[i] <= '0;
            end else if (deg_r[i] != DW'(DEG_CYC)) begin
                deg_r[i] <= deg_r[i] + DW'(1);
            end
        end
        assign trip[i] = (deg_r[i] == DW'(DEG_CYC - 1)) && sync2_r[i];
    end

    assign temp_fault = |trip;
    assign ext_fault = (phase_r == tsc_pkg::TSC_MONITOR) && sync2_r[tsc_pkg::SYN_CTRL];

    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            ctrl_flag_r <= 1'b0;
        end else if (ext_fault) begin
            ctrl_flag_r <= 1'b1;
        end
    end

    // shutdown on pin command or temperature trip, held until reset
    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            ts_off_r <= 1'b0;
        end else if (ext_fault || temp_fault) begin
            ts_off_r <= 1'b1;
        end
    end

    assign die_trip = sync2_r[tsc_pkg::SYN_DIE_HOT] && !die_off_r;

    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            die_off_r <= 1'b0;
        end else if (sync2_r[tsc_pkg::SYN_DIE_HOT]) begin
            die_off_r <= 1'b1;
        end else if (sync2_r[tsc_pkg::SYN_DIE_COOL]) begin
            die_off_r <= 1'b0;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            ldo_en <= 1'b0;
        end else begin
            ldo_en <= !die_off_r && !ts_off_r && !sync2_r[tsc_pkg::SYN_DIE_HOT];
        end
    end

    // A new fault in the send cycle re-arms the request, so the clear does not drop that fault.
    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            ept_req_r <= 1'b0;
            reason_r <= tsc_pkg::EPT_UNKNOWN;
        end else begin
            if (tx_start && ept_req_r) begin
                ept_req_r <= 1'b0;
            end
            if (die_trip) begin
                ept_req_r <= 1'b1;
                reason_r <= tsc_pkg::EPT_INT_FAULT;
            end else if (!ts_off_r && ext_fault) begin
                ept_req_r <= 1'b1;
                reason_r <= tsc_pkg::EPT_UNKNOWN;
            end else if (!ts_off_r && temp_fault) begin
                ept_req_r <= 1'b1;
                reason_r <= tsc_pkg::EPT_OVER_TEMP;
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            rx_power_r <= '0;
        end else begin
            rx_power_r <= {1'b0, out_power} + {1'b0, loss_power};
        end
    end

    // The packet carries one power byte, so large values saturate rather than wrap.
    assign pwr_byte = (rx_power_r > (PWR_W + 1)'(tsc_pkg::PWR_SAT)) ? tsc_pkg::PWR_SAT
                                                                    : rx_power_r[7:0];

    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            pwr_req_r <= 1'b0;
        end else begin
            if (tx_start && !ept_req_r) begin
                pwr_req_r <= 1'b0;
            end
            if (mon_end && ldo_en) begin
                pwr_req_r <= 1'b1;
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            ended_r <= 1'b0;
        end else if (tx_start && ept_req_r) begin
            ended_r <= 1'b1;
        end else if (!die_off_r && !ts_off_r) begin
            ended_r <= 1'b0;
        end
    end

    // End-transfer messages take precedence over power reports.
    assign tx_start = !tx_busy && (ept_req_r || pwr_req_r);
    assign hdr = ept_req_r ? tsc_pkg::EPT_HDR : tsc_pkg::RXPWR_HDR;
    assign body = ept_req_r ? reason_r : pwr_byte;
    assign pkt = {hdr ^ body, body, hdr};

    tsc_biphase_tx #(
        .HALF_CYC(HALF_BIT_CYC),
        .BYTES(tsc_pkg::PKT_BYTES)
    ) u_tx (
        .sys_clk(sys_clk),
        .nrst(nrst),
        .start(tx_start),
        .pkt(pkt),
        .busy(tx_busy),
        .mod_out(comm_mod)
    );

    assign ctrl_flag = ctrl_flag_r;
    assign transfer_ended = ended_r;
    assign ept_reason = reason_r;
    assign rx_power = rx_power_r;
    assign comm_busy = tx_busy;
endmodule

/* verification/tsc_ctrl_assertions.sv */
`timescale 1ns/1ps
module tsc_chk #(
    parameter int BIAS_CYC = 40,
    parameter int PRI_CYC = 60,
    parameter int STD_CYC = 100,
    parameter int HALF_BIT_CYC = 4
) (
    input wire logic sys_clk,
    input wire logic nrst,
    input wire logic hot_cmp,
    input wire logic die_hot,
    input wire logic die_cool,
    input wire logic temp_bias_read_window,
    input wire logic sense_pin_o,
    input wire logic sense_pin_oe,
    input wire logic ldo_en,
    input wire logic ctrl_flag,
    input wire logic [7:0] ept_reason,
    input wire logic comm_mod,
    input wire logic comm_busy
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!nrst);
    logic win_d;
    logic seen;
    int pcnt;
    int bcnt;
    int cage;
    wire rise = temp_bias_read_window && !win_d;
    always_ff @(posedge sys_clk) begin
        win_d <= nrst && temp_bias_read_window;
    end
    // A period only counts when power stayed on since the previous window.
    always_ff @(posedge sys_clk) begin
        seen <= (nrst && ldo_en) && (seen || rise);
    end
    always_ff @(posedge sys_clk) begin
        pcnt <= rise ? 1 : pcnt + 1;
    end
    always_ff @(posedge sys_clk) begin
        bcnt <= (nrst && comm_busy) ? bcnt + 1 : 0;
    end
    always_ff @(posedge sys_clk) begin
        cage <= (!nrst || die_cool) ? 0 : cage + 1;
    end
    AST_PIN_DRIVE: assert property (
        sense_pin_oe == temp_bias_read_window && sense_pin_o == sense_pin_oe)
        else $error("pin drive differs from read window");
    AST_WIN_LEN: assert property (
        temp_bias_read_window && win_d |-> pcnt < BIAS_CYC)
        else $error("read window too long");
    AST_PERIOD: assert property (
        rise && seen |-> pcnt == BIAS_CYC + PRI_CYC || pcnt == BIAS_CYC + STD_CYC)
        else $error("window period wrong");
    AST_CTRL_SET: assert property (
        $rose(ctrl_flag) |-> !$past(sense_pin_oe) && ept_reason == 8'h00 ##1 !ldo_en)
        else $error("external control handling wrong");
    AST_TS_TRIP: assert property (
        (hot_cmp && temp_bias_read_window)[*3] ##1 hot_cmp[*3]
        |-> !ldo_en && ept_reason == 8'h03)
        else $error("hot trip in window not acted on");
    AST_DIE_OFF: assert property (
        die_hot[*8] |-> !ldo_en && ept_reason == 8'h02)
        else $error("die shutdown missing");
    AST_DIE_RESUME: assert property (
        $rose(ldo_en) && $past(nrst, 2) |-> cage < 8)
        else $error("regulator back on before die cooled");
    AST_MSG_START: assert property (
        $rose(comm_busy) |-> comm_mod != $past(comm_mod))
        else $error("no transition at message start");
    AST_MSG_IDLE: assert property (
        !comm_busy && !$past(comm_busy) |-> $stable(comm_mod))
        else $error("modulator moved while idle");
    AST_MSG_LEN: assert property (
        $fell(comm_busy) |-> bcnt == 66 * HALF_BIT_CYC)
        else $error("message length wrong");
endmodule
bind tsc_ctrl tsc_chk #(.BIAS_CYC(BIAS_CYC), .PRI_CYC(PRI_CYC), .STD_CYC(STD_CYC),
    .HALF_BIT_CYC(HALF_BIT_CYC)) u_chk (.sys_clk, .nrst, .hot_cmp, .die_hot, .die_cool,
    .temp_bias_read_window, .sense_pin_o, .sense_pin_oe, .ldo_en, .ctrl_flag, .ept_reason,
    .comm_mod, .comm_busy);

/* verification/tsc_host_model.sv */
`timescale 1ns/1ps
module tsc_host_model (
    input wire logic [1:0] mode,
    input wire logic ntc_hot,
    input wire logic ntc_cold,
    output logic term,
    output logic fault,
    output logic hot_cmp,
    output logic cold_cmp,
    output logic ctrl_high_cmp
);
    assign term = (mode != 2'h1);
    assign fault = (mode == 2'h2);
    wire bat = !term && !fault;
    wire gnd = term && fault;
    // A pulled pin overrides the divider whether or not the bias is on.
    assign hot_cmp = gnd || (ntc_hot && !bat);
    assign cold_cmp = bat || (ntc_cold && !gnd);
    assign ctrl_high_cmp = bat;
endmodule

/* verification/testbench.sv */
`timescale 1ns/1ps
module testbench;
    localparam int HB = 4;
    logic sys_clk = 1'b0;
    logic nrst = 1'b0;
    logic die_hot = 1'b0;
    logic die_cool = 1'b0;
    logic prio = 1'b1;
    logic ntc_hot = 1'b0;
    logic ntc_cold = 1'b0;
    logic [1:0] mode = 2'h0;
    logic [15:0] out_p = 16'h0030;
    logic [15:0] loss_p = 16'h0012;
    logic hot, cold, ctrl_hi, win, pin_o, pin_oe, ldo, flag, ended, cmod, cbusy;
    logic [7:0] reason;
    logic [7:0] c;
    logic [16:0] rxp;
    logic [32:0] g;
    int n_fail = 0;
    int checked = 0;
    int cyc = 0;
    always #50 sys_clk = ~sys_clk;
    tsc_host_model u_host (.mode(mode), .ntc_hot(ntc_hot), .ntc_cold(ntc_cold), .term(),
        .fault(), .hot_cmp(hot), .cold_cmp(cold), .ctrl_high_cmp(ctrl_hi));
    tsc_ctrl #(.BIAS_CYC(40), .PRI_CYC(60), .STD_CYC(100), .HALF_BIT_CYC(HB), .DEG_CYC(3)) DUT (
        .sys_clk(sys_clk), .nrst(nrst), .hot_cmp(hot), .cold_cmp(cold), .ctrl_high_cmp(ctrl_hi),
        .die_hot(die_hot), .die_cool(die_cool), .priority_period(prio), .out_power(out_p),
        .loss_power(loss_p), .temp_bias_read_window(win), .sense_pin_o(pin_o),
        .sense_pin_oe(pin_oe), .ldo_en(ldo), .ctrl_flag(flag), .transfer_ended(ended),
        .ept_reason(reason), .rx_power(rxp), .comm_mod(cmod), .comm_busy(cbusy));
    task automatic end_sim();
        $display("checked %0d n_fail %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    task automatic chk(input logic [35:0] got, input logic [35:0] exp);
        checked++;
        if (got !== exp) begin
            n_fail++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    function automatic logic [10:0] fr(input logic [7:0] b);
        return {1'b1, ~^b, b, 1'b0};
    endfunction
    function automatic logic [32:0] pkt(input logic [7:0] h, input logic [7:0] b);
        return {fr(h ^ b), fr(b), fr(h)};
    endfunction
    task automatic till(input logic v, ref logic s);
        int i;
        i = 0;
        while (s !== v && i < 3000) begin
            @(negedge sys_clk);
            i++;
        end
    endtask
    task automatic rst();
        nrst = 1'b0;
        mode = 2'h0;
        ntc_cold = 1'b0;
        die_hot = 1'b0;
        repeat (4) @(negedge sys_clk);
        chk({win, pin_oe, ldo, flag, ended, reason, cmod, cbusy, rxp}, 36'h0);
        nrst = 1'b1;
        @(negedge sys_clk);
    endtask
    // Skips messages of other kinds, so a pending power report cannot hide the wanted one.
    task automatic get_msg(input logic [7:0] h, input logic [7:0] b);
        logic x, y, p;
        logic [32:0] e;
        int n;
        n = 0;
        g = '0;
        while (g !== pkt(h, b) && n < 4) begin
            n++;
            till(1'b0, cbusy);
            till(1'b1, cbusy);
            p = cmod;
            for (int i = 0; i < 33; i++) begin
                repeat (HB / 2) @(negedge sys_clk);
                x = cmod;
                repeat (HB) @(negedge sys_clk);
                y = cmod;
                repeat (HB / 2) @(negedge sys_clk);
                g[i] = x ^ y;
                e[i] = x ^ p;
                p = y;
            end
            chk(e[32:1], {32{1'b1}});
        end
        chk(g, pkt(h, b));
    endtask
    always @(posedge sys_clk) begin
        cyc++;
        if (cyc == 30000) begin
            n_fail++;
            end_sim();
        end
    end
    initial begin
        rst();
        chk({win, pin_o, pin_oe, ldo}, 36'hf);
        till(1'b0, win);
        ntc_hot = 1'b1;
        repeat (30) @(negedge sys_clk);
        ntc_hot = 1'b0;
        repeat (20) @(negedge sys_clk);
        chk({ldo, flag, rxp}, {2'b10, 17'h42});
        get_msg(8'h04, 8'h42);
        out_p = 16'h00f0;
        loss_p = 16'h0020;
        prio = 1'b0;
        get_msg(8'h04, 8'hff);
        for (int k = 0; k < 4; k++) begin
            rst();
            till(1'b0, win);
            c = (k == 3) ? 8'h02 : (k == 0) ? 8'h00 : 8'h03;
            mode = (k == 0) ? 2'h1 : (k == 1) ? 2'h2 : 2'h0;
            ntc_cold = (k == 2);
            die_hot = (k == 3);
            get_msg(8'h02, c);
            chk({flag, ldo, ended, reason}, {1'(k == 0), 2'b01, c});
        end
        die_hot = 1'b0;
        repeat (20) @(negedge sys_clk);
        chk(ldo, 1'b0);
        die_cool = 1'b1;
        repeat (6) @(negedge sys_clk);
        chk(ldo, 1'b1);
        end_sim();
    end
endmodule
